// ===== design/spe_pkg.sv
// Shared constants and types of the protected two-wire memory slave.
package spe_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DEPTH = 256;

  localparam logic [3:0] MEM_PREFIX = 4'ha;
  localparam logic [3:0] PROT_PREFIX = 4'h6;
  localparam logic [7:0] LOW_HALF_LAST = 8'h7f;

  localparam logic [3:0] RX_BITS = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;
  localparam logic [1:0] BYTE_SLAVE = 2'h0;
  localparam logic [1:0] BYTE_WORD = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;

  // Pin order is {scl, sda, inhibit, strap a, strap b, strap c}.
  localparam logic [5:0] SYNC_INIT = 6'h30;
  localparam logic STANDBY_RST = 1'b1;
  localparam logic PROT_BLANK = 1'b0;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_RX_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_TX_ACK = 6'h10,
    ST_WAIT = 6'h20
  } spe_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } spe_bus_t;

endpackage

// ===== design/spe_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module spe_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule
`default_nettype wire

// ===== design/spe_cond.sv
// Start, stop and clock edge detector on the synchronised bus lines.
`timescale 1ns/1ps
`default_nettype none
module spe_cond (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl,
  input wire logic sda,
  output var spe_pkg::spe_bus_t ev
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  always_comb begin
    ev.scl = scl;
    ev.sda = sda;
    ev.scl_rise = scl & ~scl_q;
    ev.scl_fall = ~scl & scl_q;
    ev.start = scl & scl_q & sda_q & ~sda; // [RQ7]
    ev.stop = scl & scl_q & ~sda_q & sda; // [RQ8]
  end
endmodule
`default_nettype wire

// ===== design/spe_slave.sv
// Two-wire slave engine with array and write protection.
`timescale 1ns/1ps
`default_nettype none
// What this block does, and what it relies on the bus master to do
// [RQ1] No array write while inhibit pin high.
// [RQ2] Inhibit input defaults low, writes enabled.
// [RQ3] Protection refuses writes to lower half.
// [RQ4] Protection bit is sticky and nonvolatile.
// [RQ5] Inhibit pin blocks whole array always.
// [RQ6] Protect command programs the protection bit.
// [RQ7] Data fall with clock high starts.
// [RQ8] Data rise with clock high stops.
// [RQ9] Stop after read enters standby.
// [RQ10] Data line changes only while clock low.
// [RQ11] Receiver pulls data low on ninth clock.
// [RQ12] Acknowledge only a matching slave address.
// [RQ13] Acknowledge every byte of a write.
// [RQ14] Send next byte after master acknowledge.
// [RQ15] On master no-ack, release and await stop.
// [RQ16] Prefix selects memory or protect command.
// [RQ17] Three address bits must match straps.
// [RQ18] Last address bit selects read or write.
// [RQ19] Data line pulled low or released only.
// [RQ20] Master ends every transfer with stop.
// [RQ21] Master keeps inhibit steady during transfer.
// [RQ22] Protect command bytes acknowledged, values ignored.
// [RQ23] No acknowledge for protect prefix with read.
// [RQ24] Further protect commands have no effect.
// [RQ25] Refused writes still complete the handshake.
module spe_slave (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_inhibit_pin,
  input wire logic strap_addr_bit_a,
  input wire logic strap_addr_bit_b,
  input wire logic strap_addr_bit_c,
  output logic standby,
  output logic sw_protect
);
  logic [5:0] pins_raw;
  logic [5:0] pins_s;
  logic wi_s;
  logic [2:0] strap_s;
  spe_pkg::spe_bus_t ev;

  spe_pkg::spe_state_t st_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] byte_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] addr_q;
  logic is_read_q;
  logic is_prot_q;
  logic mst_ack_q;
  logic prot_pend_q;
  logic prot_q = spe_pkg::PROT_BLANK;
  logic sda_oe_q;
  logic sda_out_q;
  logic standby_q;
  logic [7:0] mem_q [0:spe_pkg::DEPTH-1];

  logic addr_match;
  logic ack_now;
  logic byte_done;
  logic wr_allowed;
  logic mem_we;
  logic tx_load;
  logic oe_event;
  logic [7:0] rd_data;

  assign pins_raw = {scl_pin, sda_in, write_inhibit_pin,
                     strap_addr_bit_a, strap_addr_bit_b, strap_addr_bit_c};

  // Inhibit resets to low so an idle pin leaves writes enabled. [RQ2]
  spe_sync #(
    .W(6),
    .INIT(spe_pkg::SYNC_INIT)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .d(pins_raw),
    .q(pins_s)
  );

  assign wi_s = pins_s[3];
  assign strap_s = pins_s[2:0];

  spe_cond u_cond (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .scl(pins_s[5]),
    .sda(pins_s[4]),
    .ev(ev)
  );

  // Protect prefix is only taken with the write direction. [RQ16] [RQ23]
  assign addr_match = (shift_q[3:1] == strap_s) && // [RQ17]
    ((shift_q[7:4] == spe_pkg::MEM_PREFIX) ||
     ((shift_q[7:4] == spe_pkg::PROT_PREFIX) && !shift_q[0]));

  // Later bytes are only ever received in write mode. [RQ12] [RQ13] [RQ22]
  assign ack_now = (byte_cnt_q == spe_pkg::BYTE_SLAVE) ? addr_match
                                                        : !is_read_q;

  assign byte_done = (st_q == spe_pkg::ST_RX) && ev.scl_fall &&
                     (bit_cnt_q == spe_pkg::RX_BITS);

  // The inhibit level is sampled per byte, which is safe only because the
  // master holds it steady for the whole transfer. [RQ21]
  assign wr_allowed = !wi_s && // [RQ1] [RQ5]
                      !(prot_q && (addr_q <= spe_pkg::LOW_HALF_LAST)); // [RQ3]

  assign mem_we = byte_done && (byte_cnt_q == spe_pkg::BYTE_DATA) &&
                  !is_prot_q && wr_allowed; // [RQ25]

  assign tx_load = ev.scl_fall &&
    (((st_q == spe_pkg::ST_RX_ACK) && is_read_q) ||
     ((st_q == spe_pkg::ST_TX_ACK) && mst_ack_q)); // [RQ14]

  assign rd_data = mem_q[addr_q];
  assign oe_event = ev.scl_fall | ev.start | ev.stop;

  // Protocol sequencer; data line moves only on a clock fall. [RQ10]
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= spe_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      byte_cnt_q <= spe_pkg::BYTE_SLAVE;
      sda_oe_q <= 1'b0;
      is_read_q <= 1'b0;
      is_prot_q <= 1'b0;
      mst_ack_q <= 1'b0;
    end else if (ce) begin
      if (ev.stop) begin
        st_q <= spe_pkg::ST_IDLE; // [RQ8] [RQ20]
        sda_oe_q <= 1'b0;
      end else if (ev.start) begin
        st_q <= spe_pkg::ST_RX; // [RQ7]
        bit_cnt_q <= 4'h0;
        byte_cnt_q <= spe_pkg::BYTE_SLAVE;
        sda_oe_q <= 1'b0;
      end else begin
        case (st_q)
          spe_pkg::ST_RX: begin
            if (ev.scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (byte_done) begin
              if (ack_now) begin
                st_q <= spe_pkg::ST_RX_ACK;
                sda_oe_q <= 1'b1; // [RQ11] [RQ12] [RQ13]
                if (byte_cnt_q == spe_pkg::BYTE_SLAVE) begin
                  is_read_q <= shift_q[0]; // [RQ18]
                  is_prot_q <= (shift_q[7:4] == spe_pkg::PROT_PREFIX);
                end
              end else begin
                st_q <= spe_pkg::ST_WAIT; // [RQ12]
              end
            end
          end
          spe_pkg::ST_RX_ACK: begin
            if (ev.scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (byte_cnt_q != spe_pkg::BYTE_DATA) begin
                byte_cnt_q <= byte_cnt_q + 2'h1;
              end
              if (is_read_q) begin
                st_q <= spe_pkg::ST_TX;
                sda_oe_q <= !rd_data[7]; // [RQ19]
              end else begin
                st_q <= spe_pkg::ST_RX;
                sda_oe_q <= 1'b0; // [RQ11]
              end
            end
          end
          spe_pkg::ST_TX: begin
            if (ev.scl_fall) begin
              if (bit_cnt_q == spe_pkg::TX_LAST_BIT) begin
                st_q <= spe_pkg::ST_TX_ACK;
                sda_oe_q <= 1'b0; // [RQ11] [RQ14]
              end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                sda_oe_q <= !tx_q[6]; // [RQ19]
              end
            end
          end
          spe_pkg::ST_TX_ACK: begin
            if (ev.scl_rise) begin
              mst_ack_q <= !ev.sda; // [RQ14]
            end else if (ev.scl_fall) begin
              if (mst_ack_q) begin
                st_q <= spe_pkg::ST_TX;
                bit_cnt_q <= 4'h0;
                sda_oe_q <= !rd_data[7]; // [RQ14]
              end else begin
                st_q <= spe_pkg::ST_WAIT; // [RQ15]
              end
            end
          end
          spe_pkg::ST_WAIT: begin
            sda_oe_q <= 1'b0; // [RQ15]
          end
          spe_pkg::ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            st_q <= spe_pkg::ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      shift_q <= 8'h00;
    end else if (ce) begin
      if (ev.start) begin
        shift_q <= 8'h00;
      end else if ((st_q == spe_pkg::ST_RX) && ev.scl_rise) begin
        shift_q <= {shift_q[6:0], ev.sda};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_q <= 8'h00;
    end else if (ce) begin
      if (tx_load) begin
        tx_q <= rd_data;
      end else if ((st_q == spe_pkg::ST_TX) && ev.scl_fall) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // Writes roll within a 16-byte page, reads roll over the whole array.
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_q <= 8'h00;
    end else if (ce) begin
      if (byte_done && (byte_cnt_q == spe_pkg::BYTE_WORD) && !is_prot_q) begin
        addr_q <= shift_q;
      end else if (byte_done && (byte_cnt_q == spe_pkg::BYTE_DATA) &&
                   !is_prot_q) begin
        addr_q <= {addr_q[7:4], addr_q[3:0] + 4'h1};
      end else if (tx_load) begin
        addr_q <= addr_q + 8'h01;
      end
    end
  end

  // The array is nonvolatile, so reset leaves its contents alone.
  always_ff @(posedge clock) begin
    if (ce && mem_we) begin
      mem_q[addr_q] <= shift_q; // [RQ1] [RQ3] [RQ25]
    end
  end

  // Protect bytes are acknowledged but their values never stored. [RQ22]
  always_ff @(posedge clock) begin
    if (rst) begin
      prot_pend_q <= 1'b0;
    end else if (ce) begin
      if (ev.start || ev.stop) begin
        prot_pend_q <= 1'b0;
      end else if (byte_done && (byte_cnt_q == spe_pkg::BYTE_DATA) &&
                   is_prot_q) begin
        prot_pend_q <= 1'b1; // [RQ6]
      end
    end
  end

  // No reset and no clear path: the bit models a fuse that survives
  // power loss, so once set it can only stay set. [RQ4] [RQ24]
  always_ff @(posedge clock) begin
    if (ce && ev.stop && prot_pend_q) begin
      prot_q <= 1'b1; // [RQ6]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      standby_q <= spe_pkg::STANDBY_RST;
    end else if (ce) begin
      if (ev.stop) begin
        standby_q <= 1'b1; // [RQ9]
      end else if (ev.start) begin
        standby_q <= 1'b0;
      end
    end
  end

  // The pad data is held at zero; only the enable toggles. [RQ19]
  always_ff @(posedge clock) begin
    if (rst) begin
      sda_out_q <= 1'b0;
    end else if (ce) begin
      sda_out_q <= 1'b0;
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;
  assign standby = standby_q;
  assign sw_protect = prot_q;

  drive_low_a: assert property ( // [RQ19]
    @(posedge clock) disable iff (rst) sda_oe_q |-> !sda_out_q)
    else $error("Data line driven high.");

  hw_block_a: assert property ( // [RQ1]
    @(posedge clock) disable iff (rst) (ce && mem_we) |-> !wi_s)
    else $error("Array written while inhibit is high.");

  low_half_a: assert property ( // [RQ3]
    @(posedge clock) disable iff (rst)
    (ce && mem_we && prot_q) |-> (addr_q > spe_pkg::LOW_HALF_LAST))
    else $error("Protected lower half written.");

  prot_keep_a: assert property ( // [RQ4]
    @(posedge clock) disable iff (rst) prot_q |=> prot_q)
    else $error("Protection bit cleared.");

  prot_program_a: assert property ( // [RQ6]
    @(posedge clock) disable iff (rst)
    (ce && ev.stop && prot_pend_q) |=> (prot_q && !prot_pend_q))
    else $error("Protect command did not program.");

  start_rx_a: assert property ( // [RQ7]
    @(posedge clock) disable iff (rst)
    (ce && ev.start) |=> ((st_q == spe_pkg::ST_RX) && !sda_oe_q &&
                          (bit_cnt_q == 4'h0)))
    else $error("Start did not open a new address byte.");

  stop_standby_a: assert property ( // [RQ9]
    @(posedge clock) disable iff (rst)
    (ce && ev.stop) |=> ((st_q == spe_pkg::ST_IDLE) && standby_q &&
                         !sda_oe_q))
    else $error("Stop did not return to standby.");

  oe_scl_low_a: assert property ( // [RQ10]
    @(posedge clock) disable iff (rst)
    $changed(sda_oe_q) |-> $past(oe_event))
    else $error("Data drive changed outside a clock fall.");

  ninth_ack_a: assert property ( // [RQ11]
    @(posedge clock) disable iff (rst)
    (st_q == spe_pkg::ST_RX_ACK) |-> sda_oe_q)
    else $error("Acknowledge not driven low.");

  addr_ok_a: assert property ( // [RQ23]
    @(posedge clock) disable iff (rst)
    ((st_q == spe_pkg::ST_RX_ACK) && (byte_cnt_q == spe_pkg::BYTE_SLAVE))
    |-> ((shift_q[3:1] == strap_s) &&
         ((shift_q[7:4] == spe_pkg::MEM_PREFIX) ||
          ((shift_q[7:4] == spe_pkg::PROT_PREFIX) && !shift_q[0]))))
    else $error("Foreign slave address acknowledged.");

  write_ack_a: assert property ( // [RQ13]
    @(posedge clock) disable iff (rst)
    (ce && byte_done && (byte_cnt_q != spe_pkg::BYTE_SLAVE) && !is_read_q)
    |=> ((st_q == spe_pkg::ST_RX_ACK) && sda_oe_q))
    else $error("Write byte not acknowledged.");

  next_byte_a: assert property ( // [RQ14]
    @(posedge clock) disable iff (rst)
    (ce && tx_load) |=> ((st_q == spe_pkg::ST_TX) && (bit_cnt_q == 4'h0)))
    else $error("Next read byte not started.");

  nack_wait_a: assert property ( // [RQ15]
    @(posedge clock) disable iff (rst)
    (ce && (st_q == spe_pkg::ST_TX_ACK) && ev.scl_fall && !mst_ack_q)
    |=> ((st_q == spe_pkg::ST_WAIT) && !sda_oe_q))
    else $error("Transmission went on after no acknowledge.");
endmodule
`default_nettype wire

// ===== verif/spe_master.sv
// Behavioural two-wire bus master that drives the slave under test.
`timescale 1ns/1ps
`default_nettype none
module spe_master (
  input wire logic clock,
  input wire logic sda_oe,
  output logic scl,
  output logic sda,
  output logic res_v,
  output logic [8:0] res
);
  logic sda_m;
  // A released data line floats up through the pull-up.
  assign sda = sda_m & ~sda_oe;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    res_v = 1'b0;
    res = 9'h000;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Sampling late in the high phase keeps clear of the slave's latency.
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    wt(3);
    sda_m <= b;
    wt(5);
    scl <= 1'b1;
    wt(5);
    r = sda;
    wt(1);
  endtask
  // A high first level gives a start, a low one a stop.
  task automatic cond(input logic first);
    scl <= 1'b0;
    wt(3);
    sda_m <= first;
    wt(3);
    scl <= 1'b1;
    wt(6);
    sda_m <= ~first;
    wt(6);
  endtask
  task automatic emit(input logic [8:0] v);
    res <= v;
    res_v <= 1'b1;
    wt(1);
    res_v <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    emit({1'b0, 7'h00, a});
  endtask
  task automatic recv(input logic nack);
    logic [7:0] q;
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, q[i]);
    bit_io(nack, a);
    emit({1'b1, q});
  endtask
endmodule
`default_nettype wire

// ===== verif/test_serial_eeprom_slave_write_protect.sv
// Self-checking bench of the protected two-wire memory slave.
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_slave_write_protect;
  localparam logic [2:0] STRAP = 3'h5;
  // The second strap value is no mirror image of the first, so a swapped
  // strap order cannot pass.
  localparam logic [2:0] STRAP_NEW = 3'h6;
  localparam logic [7:0] BAD [3] = '{8'hba, 8'ha8, 8'h6b};
  logic clock, rst, ce, inhibit;
  logic scl, sda, sda_out, sda_oe, standby, sw_protect, res_v;
  logic [8:0] res, e;
  logic [8:0] exp_q[$];
  logic [31:0] seed;
  logic [7:0] v0, v3;
  int num_errors, checks_done;
  logic [2:0] strap;
  logic [7:0] sla_w, sla_r, sla_p, ce_r;
  logic [3:0] ce_cnt = 4'h0;

  assign sla_w = {spe_pkg::MEM_PREFIX, strap, 1'b0};
  assign sla_r = {spe_pkg::MEM_PREFIX, strap, 1'b1};
  assign sla_p = {spe_pkg::PROT_PREFIX, strap, 1'b0};

  spe_slave u_dut (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .scl_pin(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .write_inhibit_pin(inhibit),
    .strap_addr_bit_a(strap[2]),
    .strap_addr_bit_b(strap[1]),
    .strap_addr_bit_c(strap[0]),
    .standby(standby),
    .sw_protect(sw_protect)
  );
  spe_master u_m (
    .clock(clock),
    .sda_oe(sda_oe),
    .scl(scl),
    .sda(sda),
    .res_v(res_v),
    .res(res)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Enable drops for at most one cycle in sixteen, at random, so every
  // bus level of three clocks or more is still seen by the slave.
  always @(posedge clock) begin
    ce_r = rnd();
    ce_cnt <= ce_cnt + 4'h1;
    ce <= !((ce_cnt == 4'hf) && ce_r[0]);
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_ack(input logic ex, input logic got);
    checks_done++;
    if (got !== ex) begin
      num_errors++;
      $display("unexpected ack bit: expected %b seen %b", ex, got);
    end
  endtask
  task automatic chk_byte(input logic [7:0] ex, input logic [7:0] got);
    checks_done++;
    if (got !== ex) begin
      num_errors++;
      $display("unexpected read byte: expected %h seen %h", ex, got);
    end
  endtask
  task automatic chk_lvl(input string nm, input logic ex, input logic got);
    checks_done++;
    if (got !== ex) begin
      num_errors++;
      $display("unexpected %s: expected %b seen %b", nm, ex, got);
    end
  endtask

  // The wire shows a low bit when the slave acknowledges.
  task automatic wr(input logic [7:0] d, input logic ack);
    exp_q.push_back({1'b0, 7'h00, ~ack});
    u_m.send(d);
  endtask
  task automatic rd(input logic nack, input logic [7:0] ex);
    exp_q.push_back({1'b1, ex});
    u_m.recv(nack);
  endtask
  task automatic mw(input logic [7:0] a, input logic [7:0] d);
    u_m.cond(1'b1);
    wr(sla_w, 1'b1);
    wr(a, 1'b1);
    wr(d, 1'b1);
    u_m.cond(1'b0);
  endtask
  task automatic mr(input logic [7:0] a);
    u_m.cond(1'b1);
    wr(sla_w, 1'b1);
    wr(a, 1'b1);
    u_m.cond(1'b1);
    wr(sla_r, 1'b1);
  endtask
  // The pin only moves between transfers.
  task automatic pin(input logic v);
    @(posedge clock);
    inhibit <= v;
  endtask

  always @(posedge clock) begin
    if (res_v === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("unexpected result %h with nothing noted", res);
      end else begin
        e = exp_q.pop_front();
        if (e[8]) begin
          chk_byte(e[7:0], res[7:0]);
        end else begin
          chk_ack(e[0], res[0]);
        end
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    end_of_test();
  end

  initial begin
    seed = 32'd35;
    num_errors = 0;
    checks_done = 0;
    rst = 1'b1;
    strap = STRAP;
    inhibit = 1'b0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    v0 = rnd();
    v3 = rnd();
    mw(8'h7f, v0);
    // A second data byte rolls within the page from 0x8f to 0x80.
    u_m.cond(1'b1);
    wr(sla_w, 1'b1);
    wr(8'h8f, 1'b1);
    wr(rnd(), 1'b1);
    wr(v3, 1'b1);
    u_m.cond(1'b0);
    mr(8'h7f);
    rd(1'b0, v0);
    rd(1'b1, v3);
    rd(1'b1, 8'hff);
    u_m.cond(1'b0);
    chk_lvl("standby", 1'b1, standby);
    for (int i = 0; i < 3; i++) begin
      u_m.cond(1'b1);
      chk_lvl("standby", 1'b0, standby);
      wr(BAD[i], 1'b0);
      u_m.cond(1'b0);
    end
    pin(1'b1);
    mw(8'h80, rnd());
    pin(1'b0);
    mr(8'h80);
    rd(1'b1, v3);
    u_m.cond(1'b0);
    chk_lvl("sw_protect", 1'b0, sw_protect);
    for (int k = 0; k < 2; k++) begin
      u_m.cond(1'b1);
      wr(sla_p, 1'b1);
      wr(rnd(), 1'b1);
      wr(rnd(), 1'b1);
      u_m.cond(1'b0);
      chk_lvl("sw_protect", 1'b1, sw_protect);
    end
    rst <= 1'b1;
    strap <= STRAP_NEW;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk_lvl("sw_protect", 1'b1, sw_protect);
    u_m.cond(1'b1);
    wr({spe_pkg::MEM_PREFIX, STRAP, 1'b0}, 1'b0);
    u_m.cond(1'b0);
    mw(8'h7f, ~v0);
    v3 = rnd();
    mw(8'h80, v3);
    mr(8'h7f);
    rd(1'b0, v0);
    rd(1'b1, v3);
    u_m.cond(1'b0);
    pin(1'b1);
    mw(8'h80, ~v3);
    pin(1'b0);
    mr(8'h80);
    rd(1'b1, v3);
    u_m.cond(1'b0);
    chk_lvl("sda_out", 1'b0, sda_out);
    repeat (4) @(posedge clock);
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("unexpected count of results: %0d missing", exp_q.size());
    end
    end_of_test();
  end
endmodule
`default_nettype wire
